// ### inc/bboe_pkg.sv
package bboe_pkg;

	// Operation codes presented by the decode path
	typedef enum logic [2:0] {
		BBOE_OP_IDLE = 3'b000,
		BBOE_OP_SUM  = 3'b001,
		BBOE_OP_ANDR = 3'b010,
		BBOE_OP_ANDK = 3'b011,
		BBOE_OP_BCLR = 3'b100,
		BBOE_OP_BSET = 3'b101,
		BBOE_OP_TSKL = 3'b110,
		BBOE_OP_TSKH = 3'b111
	} bboe_op_t;

	typedef enum logic [1:0] {
		BBOE_ST_IDLE = 2'b00,
		BBOE_ST_EXEC = 2'b01,
		BBOE_ST_WBRD = 2'b10
	} bboe_state_t;

	localparam int          BBOE_DATA_W   = 8;
	localparam int          BBOE_FADDR_W  = 5;
	localparam int          BBOE_BIDX_W   = 3;
	localparam int          BBOE_WB_ADR_W = 8;

	// Register byte offsets
	localparam logic [7:0]  BBOE_ADR_ACCUM  = 8'h00;
	localparam logic [7:0]  BBOE_ADR_STATUS = 8'h04;
	localparam logic [7:0]  BBOE_ADR_CTRL   = 8'h08;
	localparam int          BBOE_FILE_SEL_BIT = 7;

	// Status and control field positions
	localparam int          BBOE_ST_C    = 0;
	localparam int          BBOE_ST_NOVF = 1;
	localparam int          BBOE_ST_Z    = 2;
	localparam int          BBOE_ST_SKIP = 3;
	localparam int          BBOE_CTRL_RUN = 0;

	// Reset values and port register address
	localparam logic [7:0]  BBOE_ACCUM_RST = 8'h00;
	localparam logic [2:0]  BBOE_FLAGS_RST = 3'h0;
	localparam logic        BBOE_RUN_RST   = 1'b1;
	localparam logic [4:0]  BBOE_PORT_ADDR = 5'h06;

endpackage : bboe_pkg

// ### hw/bboe_filereg.sv
`timescale 1ns/100ps
`default_nettype none

module bboe_filereg #(
	parameter int ADDR_W = 5,
	parameter int WIDTH  = 8
) (
	// Clock and enable
	input  wire logic              clk_i,
	input  wire logic              ce_i,
	// Write port
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] waddr_i,
	input  wire logic [WIDTH-1:0]  wdata_i,
	// Read port, data one cycle after address
	input  wire logic [ADDR_W-1:0] raddr_i,
	output logic      [WIDTH-1:0]  rdata_o
);

	logic [WIDTH-1:0] mem_ff [2**ADDR_W];

	generate
		if (ADDR_W < 1 || WIDTH < 1) begin : g_bad
			$error("bboe_filereg: bad geometry");
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem_ff[waddr_i] <= wdata_i;
			end
			rdata_o <= mem_ff[raddr_i];
		end
	end

endmodule : bboe_filereg

`default_nettype wire

// ### hw/bboe_alu.sv
`timescale 1ns/100ps
`default_nettype none

module bboe_alu
	import bboe_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Operands
	input  wire bboe_pkg::bboe_op_t  op_i,
	input  wire logic [7:0]          accum_i,
	input  wire logic [7:0]          fval_i,
	input  wire logic [7:0]          imm_i,
	input  wire logic [2:0]          bidx_i,
	input  wire logic                dsel_i,
	// Results
	output logic      [7:0]          result_o,
	output logic                     to_accum_o,
	output logic                     to_file_o,
	output logic                     upd_cdc_o,
	output logic                     upd_z_o,
	output logic                     c_o,
	output logic                     novf_o,
	output logic                     skip_o
);

	logic [7:0] mask;
	logic [8:0] sum;
	logic [4:0] nib;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_mask
			assign mask[gi] = (bidx_i == 3'(gi));
		end
	endgenerate

	assign sum = {1'b0, accum_i} + {1'b0, fval_i};
	assign nib = {1'b0, accum_i[3:0]} + {1'b0, fval_i[3:0]};

	always_comb begin
		result_o   = fval_i;
		to_accum_o = 1'b0;
		to_file_o  = 1'b0;
		upd_cdc_o  = 1'b0;
		upd_z_o    = 1'b0;
		skip_o     = 1'b0;
		case (op_i)
			BBOE_OP_SUM: begin
				result_o   = sum[7:0];
				to_accum_o = ~dsel_i;
				to_file_o  = dsel_i;
				upd_cdc_o  = 1'b1;
				upd_z_o    = 1'b1;
			end
			BBOE_OP_ANDR: begin
				result_o   = accum_i & fval_i;
				to_accum_o = ~dsel_i;
				to_file_o  = dsel_i;
				upd_z_o    = 1'b1;
			end
			BBOE_OP_ANDK: begin
				result_o   = accum_i & imm_i;
				to_accum_o = 1'b1;
				upd_z_o    = 1'b1;
			end
			BBOE_OP_BCLR: begin
				result_o  = fval_i & ~mask;
				to_file_o = 1'b1;
			end
			BBOE_OP_BSET: begin
				result_o  = fval_i | mask;
				to_file_o = 1'b1;
			end
			BBOE_OP_TSKL: skip_o = ~|(fval_i & mask);
			BBOE_OP_TSKH: skip_o = |(fval_i & mask);
			default: skip_o = 1'b0;
		endcase
	end

	assign c_o  = sum[8];
	assign novf_o = nib[4];

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_mask_one_hot: assert property ($onehot(mask)) else $error("bit mask not one-hot");

endmodule : bboe_alu

`default_nettype wire

// ### hw/bboe_core.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Sum accumulator and register, update carry flags
// - AND register with accumulator, Z updated
// - AND accumulator with literal into accumulator
// - Clear one chosen register bit, flags untouched
// - Set one chosen register bit, flags untouched
// - Skip next instruction when tested bit low
// - Skip next instruction when tested bit high
// - Skipped instruction discarded with a flush pulse, no execute cycle
// - Register address 0-31, bit index 0-7
// - Port register operands read from pins
module bboe_core
	import bboe_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = BBOE_PORT_ADDR
) (
	// Clock, enable, reset
	input  wire logic                clk_i,
	input  wire logic                ce_i,
	input  wire logic                rst_i,
	// Instruction from decode
	input  wire logic                instr_valid_i,
	input  wire bboe_pkg::bboe_op_t  instr_op_i,
	input  wire logic [4:0]          instr_faddr_i,
	input  wire logic [2:0]          instr_bidx_i,
	input  wire logic                instr_dsel_i,
	input  wire logic [7:0]          instr_imm_i,
	output logic                     instr_ready_o,
	output logic                     flush_o,
	// Port pins and output latch
	input  wire logic [7:0]          port_pins_i,
	output logic      [7:0]          port_o,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	input  wire logic [3:0]          wb_sel_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o
);

	import bboe_pkg::*;

	bboe_state_t st_ff, nxt_st;
	bboe_op_t    op_ff, nxt_op;
	logic [4:0]  faddr_ff, nxt_faddr;
	logic [2:0]  bidx_ff, nxt_bidx;
	logic        dsel_ff, nxt_dsel;
	logic [7:0]  imm_ff, nxt_imm;
	logic [7:0]  accum_ff, nxt_accum;
	logic [2:0]  flags_ff, nxt_flags;
	logic        skip_ff, nxt_skip;
	logic        run_ff, nxt_run;
	logic        ready_ff, nxt_ready;
	logic        flush_ff, nxt_flush;
	logic [7:0]  port_ff, nxt_port;
	logic        ack_ff, nxt_ack;
	logic [31:0] dat_ff, nxt_dat;
	logic [7:0]  pins_meta_ff, pins_sync_ff;

	logic        mem_we;
	logic [4:0]  mem_waddr, mem_raddr;
	logic [7:0]  mem_wdata, mem_rdata;
	logic [7:0]  opnd_val;
	logic        wb_req, take_instr, take_wb, wb_file;
	logic [4:0]  wb_index;

	logic [7:0]  alu_result;
	logic        alu_to_accum, alu_to_file, alu_upd_cdc, alu_upd_z;
	logic        alu_c, alu_novf, alu_skip;

	// Pin levels cross into the clock domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_meta_ff <= 8'h00;
			pins_sync_ff <= 8'h00;
		end else if (ce_i) begin
			pins_meta_ff <= port_pins_i;
			pins_sync_ff <= pins_meta_ff;
		end
	end

	bboe_filereg #(
		.ADDR_W (BBOE_FADDR_W),
		.WIDTH  (BBOE_DATA_W)
	) u_filereg (
		.clk_i   (clk_i),
		.ce_i    (ce_i),
		.we_i    (mem_we),
		.waddr_i (mem_waddr),
		.wdata_i (mem_wdata),
		.raddr_i (mem_raddr),
		.rdata_o (mem_rdata)
	);

	// Port register reads return pin levels, not the latch
	assign opnd_val = (faddr_ff == PORT_ADDR) ? pins_sync_ff : mem_rdata;

	bboe_alu u_alu (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.op_i       (op_ff),
		.accum_i    (accum_ff),
		.fval_i     (opnd_val),
		.imm_i      (imm_ff),
		.bidx_i     (bidx_ff),
		.dsel_i     (dsel_ff),
		.result_o   (alu_result),
		.to_accum_o (alu_to_accum),
		.to_file_o  (alu_to_file),
		.upd_cdc_o  (alu_upd_cdc),
		.upd_z_o    (alu_upd_z),
		.c_o        (alu_c),
		.novf_o     (alu_novf),
		.skip_o     (alu_skip)
	);

	assign wb_req     = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wb_file    = wb_adr_i[BBOE_FILE_SEL_BIT];
	assign wb_index   = wb_adr_i[6:2];
	assign take_instr = (st_ff == BBOE_ST_IDLE) & ready_ff & instr_valid_i;
	assign take_wb    = (st_ff == BBOE_ST_IDLE) & wb_req & ~take_instr;

	// Read address: the instruction operand or the software index
	assign mem_raddr = take_instr ? instr_faddr_i : wb_index;

	// Single write port shared by execution and software
	always_comb begin
		mem_we    = 1'b0;
		mem_waddr = faddr_ff;
		mem_wdata = alu_result;
		if (st_ff == BBOE_ST_EXEC) begin
			mem_we = alu_to_file;
		end else if (take_wb && wb_file && wb_we_i && wb_sel_i[0]) begin
			mem_we    = 1'b1;
			mem_waddr = wb_index;
			mem_wdata = wb_dat_i[7:0];
		end
	end

	always_comb begin
		nxt_st    = st_ff;
		nxt_op    = op_ff;
		nxt_faddr = faddr_ff;
		nxt_bidx  = bidx_ff;
		nxt_dsel  = dsel_ff;
		nxt_imm   = imm_ff;
		nxt_accum = accum_ff;
		nxt_flags = flags_ff;
		nxt_skip  = skip_ff;
		nxt_run   = run_ff;
		nxt_flush = 1'b0;
		nxt_ack   = 1'b0;
		nxt_dat   = dat_ff;
		nxt_port  = port_ff;
		if (mem_we && mem_waddr == PORT_ADDR) begin
			nxt_port = mem_wdata;
		end
		case (st_ff)
			BBOE_ST_IDLE: begin
				if (take_instr && skip_ff) begin
					nxt_skip  = 1'b0;
					nxt_flush = 1'b1;
				end else if (take_instr) begin
					nxt_st    = BBOE_ST_EXEC;
					nxt_op    = instr_op_i;
					nxt_faddr = instr_faddr_i;
					nxt_bidx  = instr_bidx_i;
					nxt_dsel  = instr_dsel_i;
					nxt_imm   = instr_imm_i;
				end else if (take_wb && wb_file && !wb_we_i) begin
					nxt_st    = BBOE_ST_WBRD;
					nxt_faddr = wb_index;
				end else if (take_wb) begin
					nxt_ack = 1'b1;
					nxt_dat = 32'h0000_0000;
					case (wb_adr_i)
						BBOE_ADR_ACCUM: begin
							nxt_dat[7:0] = accum_ff;
							if (wb_we_i && wb_sel_i[0]) begin
								nxt_accum = wb_dat_i[7:0];
							end
						end
						BBOE_ADR_STATUS: begin
							nxt_dat[2:0]         = flags_ff;
							nxt_dat[BBOE_ST_SKIP] = skip_ff;
							if (wb_we_i && wb_sel_i[0]) begin
								nxt_flags = wb_dat_i[2:0];
							end
						end
						BBOE_ADR_CTRL: begin
							nxt_dat[BBOE_CTRL_RUN] = run_ff;
							if (wb_we_i && wb_sel_i[0]) begin
								nxt_run = wb_dat_i[BBOE_CTRL_RUN];
							end
						end
						default: nxt_dat = 32'h0000_0000;
					endcase
				end
			end
			BBOE_ST_EXEC: begin
				nxt_st = BBOE_ST_IDLE;
				if (alu_to_accum) begin
					nxt_accum = alu_result;
				end
				if (alu_upd_cdc) begin
					nxt_flags[BBOE_ST_C]  = alu_c;
					nxt_flags[BBOE_ST_NOVF] = alu_novf;
				end
				if (alu_upd_z) begin
					nxt_flags[BBOE_ST_Z] = (alu_result == 8'h00);
				end
				nxt_skip = alu_skip;
			end
			BBOE_ST_WBRD: begin
				nxt_st       = BBOE_ST_IDLE;
				nxt_ack      = 1'b1;
				nxt_dat      = 32'h0000_0000;
				nxt_dat[7:0] = opnd_val;
			end
			default: nxt_st = BBOE_ST_IDLE;
		endcase
		nxt_ready = (nxt_st == BBOE_ST_IDLE) & nxt_run;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff    <= BBOE_ST_IDLE;
			op_ff    <= BBOE_OP_IDLE;
			faddr_ff <= 5'h00;
			bidx_ff  <= 3'h0;
			dsel_ff  <= 1'b0;
			imm_ff   <= 8'h00;
			accum_ff <= BBOE_ACCUM_RST;
			flags_ff <= BBOE_FLAGS_RST;
			skip_ff  <= 1'b0;
			run_ff   <= BBOE_RUN_RST;
			ready_ff <= 1'b0;
			flush_ff <= 1'b0;
			port_ff  <= 8'h00;
			ack_ff   <= 1'b0;
			dat_ff   <= 32'h0000_0000;
		end else if (ce_i) begin
			st_ff    <= nxt_st;
			op_ff    <= nxt_op;
			faddr_ff <= nxt_faddr;
			bidx_ff  <= nxt_bidx;
			dsel_ff  <= nxt_dsel;
			imm_ff   <= nxt_imm;
			accum_ff <= nxt_accum;
			flags_ff <= nxt_flags;
			skip_ff  <= nxt_skip;
			run_ff   <= nxt_run;
			ready_ff <= nxt_ready;
			flush_ff <= nxt_flush;
			port_ff  <= nxt_port;
			ack_ff   <= nxt_ack;
			dat_ff   <= nxt_dat;
		end
	end

	assign instr_ready_o = ready_ff;
	assign flush_o       = flush_ff;
	assign port_o        = port_ff;
	assign wb_ack_o      = ack_ff;
	assign wb_dat_o      = dat_ff;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic exec_ce;
	assign exec_ce = (st_ff == BBOE_ST_EXEC) & ce_i;

	sequence s_skip_armed;
		exec_ce && (op_ff == BBOE_OP_TSKH) && opnd_val[bidx_ff];
	endsequence

	sequence s_discard;
		skip_ff && take_instr && ce_i ##1 flush_o && !skip_ff && (st_ff == BBOE_ST_IDLE);
	endsequence

	a_sum_accum_result: assert property (
		exec_ce && op_ff == BBOE_OP_SUM && !dsel_ff |=>
		accum_ff == 8'($past(accum_ff) + $past(opnd_val)) &&
		flags_ff[BBOE_ST_C] == ({1'b0, $past(accum_ff)} + {1'b0, $past(opnd_val)} > 9'h0ff))
		else $error("sum result or carry wrong");

	a_and_reg_dest: assert property (
		exec_ce && op_ff == BBOE_OP_ANDR && dsel_ff |->
		mem_we && mem_wdata == (accum_ff & opnd_val) ##1 $stable(accum_ff))
		else $error("register AND destination wrong");

	a_and_imm_zero: assert property (
		exec_ce && op_ff == BBOE_OP_ANDK |=>
		accum_ff == ($past(accum_ff) & $past(imm_ff)) && flags_ff[BBOE_ST_Z] == (accum_ff == 8'h00))
		else $error("literal AND result or zero flag wrong");

	a_bit_clear_write: assert property (
		exec_ce && op_ff == BBOE_OP_BCLR |->
		mem_we && !mem_wdata[bidx_ff] && ((mem_wdata | (8'h01 << bidx_ff)) == (opnd_val | (8'h01 << bidx_ff))))
		else $error("bit clear wrong");

	a_bit_set_flags: assert property (
		exec_ce && op_ff == BBOE_OP_BSET |-> mem_we && mem_wdata[bidx_ff] ##1 $stable(flags_ff))
		else $error("bit set wrong or flags changed");

	a_skip_low_arm: assert property (
		exec_ce && op_ff == BBOE_OP_TSKL |=> skip_ff == !$past(opnd_val[bidx_ff]) && $stable(flags_ff))
		else $error("skip-if-low decision wrong");

	a_skip_high_arm: assert property (s_skip_armed |=> skip_ff ##1 !(st_ff == BBOE_ST_EXEC))
		else $error("skip-if-high not armed");

	a_skip_discard: assert property (skip_ff && take_instr && ce_i |-> s_discard)
		else $error("skipped instruction not discarded");

	a_port_pin_read: assert property (
		exec_ce && faddr_ff == PORT_ADDR && (op_ff == BBOE_OP_BCLR || op_ff == BBOE_OP_BSET) |->
		(mem_wdata | (8'h01 << bidx_ff)) == (pins_sync_ff | (8'h01 << bidx_ff)))
		else $error("port operand not from pins");

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule : bboe_core

`default_nettype wire

// ### tb/bboe_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none

module bboe_fetch_model
	import bboe_pkg::*;
(
	// Clock and handshake
	input  wire logic          clk_i,
	input  wire logic          ready_i,
	// Instruction fields
	output logic               valid_o,
	output bboe_pkg::bboe_op_t op_o,
	output logic      [4:0]    faddr_o,
	output logic      [2:0]    bidx_o,
	output logic               dsel_o,
	output logic      [7:0]    imm_o
);
	initial begin
		valid_o = 1'b0;
		op_o = BBOE_OP_IDLE;
		faddr_o = 5'h00;
		bidx_o = 3'h0;
		dsel_o = 1'b0;
		imm_o = 8'h00;
	end

	// Offer one instruction and hold it until the edge that takes it
	task automatic issue(input bboe_op_t op, input logic [4:0] f, input logic [2:0] b,
		input logic d, input logic [7:0] k, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge clk_i);
		valid_o <= 1'b1;
		op_o <= op;
		faddr_o <= f;
		bidx_o <= b;
		dsel_o <= d;
		imm_o <= k;
		for (n = 0; n < 60 && !ok; n++) begin
			@(posedge clk_i);
			ok = (ready_i === 1'b1);
		end
		// Released fields show garbage, not the old value
		valid_o <= 1'b0;
		op_o <= bboe_op_t'(~op);
		faddr_o <= ~f;
		bidx_o <= ~b;
		dsel_o <= ~d;
		imm_o <= ~k;
	endtask : issue
endmodule : bboe_fetch_model

`default_nettype wire

// ### tb/tb_bboe_core.sv
`timescale 1ns/100ps
`default_nettype none

module tb_bboe_core;
	import bboe_pkg::*;

	logic        clk_i = 1'b0;
	logic        ce_i = 1'b1;
	logic        rst_i = 1'b1;
	logic [7:0]  port_pins_i = 8'h00;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        iv;
	bboe_op_t    iop;
	logic [4:0]  ifa;
	logic [2:0]  ibi;
	logic        ids;
	logic [7:0]  iim;
	logic        instr_ready_o;
	logic        flush_o;
	logic [7:0]  port_o;
	int          num_errors = 0;
	int          checks_done = 0;

	always #4 clk_i = ~clk_i;

	bboe_core dut_u (.clk_i(clk_i), .ce_i(ce_i), .rst_i(rst_i), .instr_valid_i(iv), .instr_op_i(iop),
		.instr_faddr_i(ifa), .instr_bidx_i(ibi), .instr_dsel_i(ids), .instr_imm_i(iim),
		.instr_ready_o(instr_ready_o), .flush_o(flush_o), .port_pins_i(port_pins_i), .port_o(port_o),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	bboe_fetch_model fetch_u (.clk_i(clk_i), .ready_i(instr_ready_o), .valid_o(iv), .op_o(iop),
		.faddr_o(ifa), .bidx_o(ibi), .dsel_o(ids), .imm_o(iim));

	task close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] sel,
		output logic [31:0] rd);
		int n;
		bit got;
		got = 1'b0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= sel;
		for (n = 0; n < 200 && !got; n++) begin
			@(posedge clk_i);
			got = (wb_ack_o === 1'b1);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (!got) begin
			num_errors++;
			close_out();
		end
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, 4'h1, x);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] x;
		wb(1'b0, a, 8'h00, 4'h1, x);
		chk(nm, x, {24'h0, e});
	endtask : rdc

	task automatic ex(input bboe_op_t op, input logic [4:0] f, input logic [2:0] b, input logic d,
		input logic [7:0] k);
		bit ok;
		fetch_u.issue(op, f, b, d, k, ok);
		if (!ok) begin
			num_errors++;
			close_out();
		end
	endtask : ex

	function automatic logic [7:0] fa(input logic [4:0] f);
		return {1'b1, f, 2'b00};
	endfunction : fa

	task automatic t_reset;
		logic [31:0] x;
		rdc("accum_rst", BBOE_ADR_ACCUM, 8'h00);
		rdc("status_rst", BBOE_ADR_STATUS, 8'h00);
		rdc("ctrl_rst", BBOE_ADR_CTRL, 8'h01);
		rdc("unmapped", 8'h0c, 8'h00);
		wb(1'b1, BBOE_ADR_ACCUM, 8'h5a, 4'h0, x);
		rdc("accum_nosel", BBOE_ADR_ACCUM, 8'h00);
		wr(BBOE_ADR_CTRL, 8'h00);
		repeat (3) @(posedge clk_i);
		#1 chk("ready_stopped", instr_ready_o, 1'b0);
		wr(BBOE_ADR_CTRL, 8'h01);
	endtask : t_reset

	task automatic t_sum;
		wr(BBOE_ADR_ACCUM, 8'h0f);
		wr(fa(3), 8'h01);
		wr(BBOE_ADR_STATUS, 8'h00);
		ex(BBOE_OP_SUM, 5'd3, 3'd0, 1'b0, 8'h00);
		rdc("sum_accum", BBOE_ADR_ACCUM, 8'h10);
		rdc("sum_flags", BBOE_ADR_STATUS, 8'h02);
		wr(BBOE_ADR_ACCUM, 8'h80);
		wr(fa(31), 8'h80);
		ex(BBOE_OP_SUM, 5'd31, 3'd0, 1'b1, 8'h00);
		rdc("sum_file", fa(31), 8'h00);
		rdc("sum_keep", BBOE_ADR_ACCUM, 8'h80);
		rdc("sum_cz", BBOE_ADR_STATUS, 8'h05);
	endtask : t_sum

	task automatic t_and;
		wr(BBOE_ADR_ACCUM, 8'hf0);
		wr(fa(5), 8'h3c);
		wr(BBOE_ADR_STATUS, 8'h03);
		ex(BBOE_OP_ANDR, 5'd5, 3'd0, 1'b0, 8'h00);
		rdc("andr_accum", BBOE_ADR_ACCUM, 8'h30);
		rdc("andr_flags", BBOE_ADR_STATUS, 8'h03);
		wr(fa(5), 8'h0f);
		ex(BBOE_OP_ANDR, 5'd5, 3'd0, 1'b1, 8'h00);
		rdc("andr_file", fa(5), 8'h00);
		rdc("andr_z", BBOE_ADR_STATUS, 8'h07);
		ex(BBOE_OP_ANDK, 5'd0, 3'd0, 1'b1, 8'ha5);
		rdc("andk_accum", BBOE_ADR_ACCUM, 8'h20);
		rdc("andk_z", BBOE_ADR_STATUS, 8'h03);
		ex(BBOE_OP_IDLE, 5'd5, 3'd1, 1'b1, 8'h00);
		rdc("idle_accum", BBOE_ADR_ACCUM, 8'h20);
		rdc("idle_flags", BBOE_ADR_STATUS, 8'h03);
		rdc("idle_file", fa(5), 8'h00);
	endtask : t_and

	// Low enable must hold off the bus answer until it returns
	task automatic t_freeze;
		fork
			begin
				ce_i <= 1'b0;
				repeat (6) @(posedge clk_i);
				chk("ce_freeze", wb_ack_o, 1'b0);
				ce_i <= 1'b1;
			end
			rdc("ce_resume", BBOE_ADR_ACCUM, 8'h20);
		join
	endtask : t_freeze

	task automatic t_bits;
		logic [7:0] e;
		e = 8'h00;
		wr(fa(10), 8'h00);
		wr(BBOE_ADR_STATUS, 8'h07);
		for (int b = 0; b < 8; b++) begin
			ex(BBOE_OP_BSET, 5'd10, b[2:0], 1'b0, 8'h00);
			e = e | (8'h01 << b);
			rdc("bit_set", fa(10), e);
		end
		for (int b = 0; b < 8; b++) begin
			ex(BBOE_OP_BCLR, 5'd10, b[2:0], 1'b0, 8'h00);
			e = e & ~(8'h01 << b);
			rdc("bit_clear", fa(10), e);
		end
		rdc("bit_flags", BBOE_ADR_STATUS, 8'h07);
	endtask : t_bits

	task automatic t_skip;
		bboe_op_t ops[4] = '{BBOE_OP_TSKH, BBOE_OP_TSKL, BBOE_OP_TSKL, BBOE_OP_TSKH};
		logic [2:0] bs[4] = '{3'd2, 3'd2, 3'd3, 3'd3};
		logic tk[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			wr(fa(12), 8'h04);
			wr(fa(13), 8'h22);
			wr(BBOE_ADR_ACCUM, 8'h11);
			wr(BBOE_ADR_STATUS, 8'h00);
			ex(ops[i], 5'd12, bs[i], 1'b0, 8'h00);
			rdc("skip_pend", BBOE_ADR_STATUS, {4'h0, tk[i], 3'b000});
			ex(BBOE_OP_SUM, 5'd13, 3'd0, 1'b0, 8'h00);
			#1 chk("flush", flush_o, tk[i]);
			rdc("after_skip", BBOE_ADR_ACCUM, tk[i] ? 8'h11 : 8'h33);
		end
	endtask : t_skip

	task automatic t_port;
		wr(fa(BBOE_PORT_ADDR), 8'hff);
		repeat (2) @(posedge clk_i);
		#1 chk("port_latch", port_o, 8'hff);
		@(posedge clk_i);
		port_pins_i <= 8'h0f;
		repeat (4) @(posedge clk_i);
		ex(BBOE_OP_BCLR, BBOE_PORT_ADDR, 3'd7, 1'b0, 8'h00);
		repeat (3) @(posedge clk_i);
		#1 chk("port_rmw", port_o, 8'h0f);
		rdc("port_read", fa(BBOE_PORT_ADDR), 8'h0f);
	endtask : t_port

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_sum();
		t_and();
		t_freeze();
		t_bits();
		t_skip();
		t_port();
		close_out();
	end
endmodule : tb_bboe_core

`default_nettype wire
